/* src/link_cfg_pkg.sv */
// constants and carriers for the serial link mode configuration bank
// Function
// R1: six-bit mode field, changed only while link disabled
// R2: four-bit stream count, resets to one
// R3: software limits stream count by interpolation factor
// R4: lanes equal ceiling streams over max, times base
// R5: software counts each complex pair as two
// R6: stream count changed only with link, datapath off
// R7: control register written only while link disabled
// R8: bit 6 selects vendor compatibility mode
// R9: subclass 0 releases once all lanes write
// R10: subclass 1 releases on release opportunity
// R11: bit 4 selects 8b/10b or 64b/66b
// R12: bit 1 selects offset binary or two's complement
// R13: bit 0 enables 8b/10b descrambler, reset on
// R14: 64b/66b always descrambles, ignoring bit 0
// R15: software should keep 8b/10b scrambling on
// R16: link disabled holds subsystem, counter reset, phy off
package link_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] LINK_ENABLE_OFS = 12'h100;
  localparam logic [11:0] LINK_MODE_OFS = 12'h101;
  localparam logic [11:0] STREAM_COUNT_OFS = 12'h102;
  localparam logic [11:0] LINK_CONTROL_OFS = 12'h103;
  localparam logic [11:0] DATAPATH_ENABLE_OFS = 12'h108;
  localparam logic [11:0] MODE_INFO_OFS = 12'h109;
  localparam logic [11:0] RELEASE_DELAY_OFS = 12'h106;
  localparam logic [11:0] LINK_STATUS_OFS = 12'h10A;
  localparam logic [7:0] LINK_MODE_RST = 8'h00;
  localparam logic [7:0] STREAM_COUNT_RST = 8'h01;
  localparam logic [7:0] LINK_CONTROL_RST = 8'h03;
  localparam logic [7:0] RELEASE_DELAY_RST = 8'h00;
  localparam int VENDOR_BIT = 6;
  localparam int SUBCLASS_BIT = 5;
  localparam int LINE_CODE_BIT = 4;
  localparam int FORMAT_BIT = 1;
  localparam int SCRAMBLE_BIT = 0;
  localparam logic [7:0] LINK_MODE_MASK = 8'h3F;
  localparam logic [7:0] STREAM_COUNT_MASK = 8'h0F;
  localparam logic [7:0] RELEASE_DELAY_MASK = 8'h3F;
  localparam int LANES = 2;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic vendor_compat_mode;
    logic subclass_one;
    logic line_code_select;
    logic sample_twos_comp;
    logic descrambler_on;
  } link_ctrl_t;
endpackage

/* src/lane_count_calc.sv */
// lane count from stream count and the mode's limits
`timescale 1ns/1ps
`default_nettype none
module lane_count_calc
  import link_cfg_pkg::*;
(
  input wire logic [3:0] stream_count,     // programmed streams
  input wire logic [3:0] mode_max_streams, // streams per lane group
  input wire logic [3:0] mode_base_lanes,  // lanes per group
  output logic [7:0] lane_count            // lanes to enable
);
  logic [3:0] groups;
  always_comb
  begin
    groups = 4'h0;
    // ceiling division by repeated compare; a zero limit yields zero lanes
    for (int g = 1; g <= 15; g++)
    begin
      if (mode_max_streams != 4'h0 && groups == 4'h0 &&
          ({4'h0, stream_count} <= 8'(g) * {4'h0, mode_max_streams}))
      begin
        groups = 4'(g); // R4
      end
    end
    lane_count = {4'h0, groups} * {4'h0, mode_base_lanes}; // R4
  end
endmodule
`default_nettype wire

/* src/serial_link_mode_config.sv */
// register bank configuring the serial link receiver mode
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module serial_link_mode_config
  import link_cfg_pkg::*;
(
  input wire logic ref_clk,                  // 200 MHz clock
  input wire logic resetn,                   // async reset, active low
  input wire logic [ADDR_W-1:0] bus_addr,    // register address
  input wire logic [7:0] bus_wdata,          // write data
  input wire logic bus_wr,                   // write strobe
  input wire logic bus_rd,                   // read strobe
  input wire logic [3:0] mode_max_streams,   // max streams of selected mode
  input wire logic [3:0] mode_base_lanes,    // base lanes of selected mode
  input wire logic [LANES-1:0] lane_writing, // lanes writing the elastic buffer
  input wire logic release_opportunity,      // release point from counter and delay
  output logic [7:0] bus_rdata,              // read data, cycle after strobe
  output logic [5:0] link_mode_select,       // selected interface mode
  output logic [3:0] stream_count,           // enabled sample streams
  output logic [LANES-1:0] lane_enable,      // enabled lanes
  output logic vendor_compat_mode,           // vendor compatibility
  output logic line_code_select,             // 0 8b/10b, 1 64b/66b
  output logic sample_number_format,         // 1 two's complement
  output logic descrambler_on,               // descrambler active
  output logic [5:0] release_delay,          // release delay setting
  output logic link_subsys_reset,            // holds subsystem in reset
  output logic mframe_counter_reset,         // holds multiframe counter in reset
  output logic phy_enable,                   // physical layer enable
  output logic buffer_release,               // elastic buffer released
  output logic datapath_enable               // datapath enable
);
  bus_req_t req;
  link_ctrl_t ctrl;
  logic link_enable_reg, link_enable_next;
  logic datapath_reg, datapath_next;
  logic [7:0] link_mode_reg, link_mode_next;
  logic [7:0] stream_count_reg, stream_count_next;
  logic [7:0] link_control_reg, link_control_next;
  logic [7:0] release_delay_reg, release_delay_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [LANES-1:0] lane_en_reg, lane_en_next;
  logic release_reg, release_next;
  logic descr_reg, descr_next;
  logic [LANES-1:0] ln_s1_reg, ln_s1_next;
  logic [LANES-1:0] ln_s2_reg, ln_s2_next;
  logic opp_s1_reg, opp_s1_next;
  logic opp_s2_reg, opp_s2_next;
  logic subsys_rst_reg, subsys_rst_next;
  logic frame_rst_reg, frame_rst_next;
  logic [7:0] lane_count;
  logic [LANES-1:0] lane_mask;

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
  assign ctrl = '{
    vendor_compat_mode: link_control_reg[VENDOR_BIT],
    subclass_one: link_control_reg[SUBCLASS_BIT],
    line_code_select: link_control_reg[LINE_CODE_BIT],
    sample_twos_comp: link_control_reg[FORMAT_BIT],
    descrambler_on: link_control_reg[SCRAMBLE_BIT]};

  lane_count_calc u_lanes (
    .stream_count(stream_count_reg[3:0]),
    .mode_max_streams(mode_max_streams),
    .mode_base_lanes(mode_base_lanes),
    .lane_count(lane_count)
  );

  // lanes below the computed count are enabled
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
      assign lane_mask[i] = lane_count > 8'(i); // R4
    end
  endgenerate

  // pin-side status passes two flops before use; only the second stage feeds logic
  always_comb
  begin
    ln_s1_next = lane_writing;
    ln_s2_next = ln_s1_reg;
    opp_s1_next = release_opportunity;
    opp_s2_next = opp_s1_reg;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ln_s1_reg <= '0;
      ln_s2_reg <= '0;
      opp_s1_reg <= 1'b0;
      opp_s2_reg <= 1'b0;
    end
    else
    begin
      ln_s1_reg <= ln_s1_next;
      ln_s2_reg <= ln_s2_next;
      opp_s1_reg <= opp_s1_next;
      opp_s2_reg <= opp_s2_next;
    end
  end

  // register writes; configuration is locked while the link runs
  always_comb
  begin
    link_enable_next = link_enable_reg;
    datapath_next = datapath_reg;
    link_mode_next = link_mode_reg;
    stream_count_next = stream_count_reg;
    link_control_next = link_control_reg;
    release_delay_next = release_delay_reg;
    if (req.wr)
    begin
      case (req.addr)
        LINK_ENABLE_OFS: link_enable_next = req.wdata[0];
        DATAPATH_ENABLE_OFS: datapath_next = req.wdata[0];
        LINK_MODE_OFS:
        begin
          if (!link_enable_reg)
          begin
            link_mode_next = req.wdata & LINK_MODE_MASK; // R1
          end
        end
        STREAM_COUNT_OFS:
        begin
          // the lock also guards the lane computation from glitching mid-link
          if (!link_enable_reg && !datapath_reg)
          begin
            stream_count_next = req.wdata & STREAM_COUNT_MASK; // R2 R6
          end
        end
        LINK_CONTROL_OFS:
        begin
          if (!link_enable_reg)
          begin
            link_control_next = req.wdata; // R7
          end
        end
        RELEASE_DELAY_OFS:
        begin
          if (!link_enable_reg)
          begin
            release_delay_next = req.wdata & RELEASE_DELAY_MASK;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link_enable_reg <= 1'b0;
      datapath_reg <= 1'b0;
      link_mode_reg <= LINK_MODE_RST;
      stream_count_reg <= STREAM_COUNT_RST;
      link_control_reg <= LINK_CONTROL_RST;
      release_delay_reg <= RELEASE_DELAY_RST;
    end
    else
    begin
      link_enable_reg <= link_enable_next;
      datapath_reg <= datapath_next;
      link_mode_reg <= link_mode_next;
      stream_count_reg <= stream_count_next;
      link_control_reg <= link_control_next;
      release_delay_reg <= release_delay_next;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        LINK_ENABLE_OFS: rdata_next = {7'h00, link_enable_reg};
        DATAPATH_ENABLE_OFS: rdata_next = {7'h00, datapath_reg};
        LINK_MODE_OFS: rdata_next = link_mode_reg;
        STREAM_COUNT_OFS: rdata_next = stream_count_reg;
        LINK_CONTROL_OFS: rdata_next = link_control_reg;
        RELEASE_DELAY_OFS: rdata_next = release_delay_reg;
        MODE_INFO_OFS: rdata_next = lane_count;
        LINK_STATUS_OFS: rdata_next = {6'h00, release_reg, descr_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data stands for one cycle only; the mux gives zero when no read is taken
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // reset controls follow the enable in the cycle it is written;
  // own flops so no inverter sits between a flop and the subsystem
  always_comb
  begin
    subsys_rst_next = !link_enable_next; // R16
    frame_rst_next = !link_enable_next; // R16
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      subsys_rst_reg <= 1'b1;
      frame_rst_reg <= 1'b1;
    end
    else
    begin
      subsys_rst_reg <= subsys_rst_next;
      frame_rst_reg <= frame_rst_next;
    end
  end

  // lane and descrambler controls, all forced off while the link is disabled
  always_comb
  begin
    lane_en_next = '0;
    descr_next = 1'b0;
    if (link_enable_reg)
    begin
      lane_en_next = lane_mask; // R4
      // 64b/66b ignores the scrambler bit and always descrambles
      descr_next = ctrl.line_code_select ? 1'b1 : ctrl.descrambler_on; // R13 R14
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lane_en_reg <= '0;
      descr_reg <= 1'b0;
    end
    else
    begin
      lane_en_reg <= lane_en_next;
      descr_reg <= descr_next;
    end
  end

  // release is sticky until the link drops; a zero lane count never releases
  always_comb
  begin
    release_next = 1'b0;
    if (link_enable_reg)
    begin
      if (release_reg)
      begin
        release_next = 1'b1;
      end
      else if (ctrl.subclass_one)
      begin
        // lanes must be writing too, or a release point would free an empty buffer
        release_next = opp_s2_reg && (ln_s2_reg & lane_mask) == lane_mask && lane_mask != '0; // R10
      end
      else
      begin
        release_next = (ln_s2_reg & lane_mask) == lane_mask && lane_mask != '0; // R9
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      release_reg <= 1'b0;
    end
    else
    begin
      release_reg <= release_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign link_mode_select = link_mode_reg[5:0]; // R1
  assign stream_count = stream_count_reg[3:0]; // R2
  assign lane_enable = lane_en_reg;
  assign vendor_compat_mode = ctrl.vendor_compat_mode; // R8
  assign line_code_select = ctrl.line_code_select; // R11
  assign sample_number_format = ctrl.sample_twos_comp; // R12
  assign descrambler_on = descr_reg;
  assign release_delay = release_delay_reg[5:0];
  assign link_subsys_reset = subsys_rst_reg; // R16
  assign mframe_counter_reset = frame_rst_reg; // R16
  assign phy_enable = link_enable_reg; // R16
  assign buffer_release = release_reg;
  assign datapath_enable = datapath_reg;
endmodule
`default_nettype wire

/* bench/link_cfg_sva.sv */
// assertions on the ports of the link mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module link_cfg_sva
  import link_cfg_pkg::*;
(
  input wire logic ref_clk,                  // clock
  input wire logic resetn,                   // async reset, active low
  input wire logic [LANES-1:0] lane_writing, // lanes writing the buffer
  input wire logic [5:0] link_mode_select,   // mode field
  input wire logic [3:0] stream_count,       // stream field
  input wire logic [LANES-1:0] lane_enable,  // enabled lanes
  input wire logic vendor_compat_mode,       // bit 6
  input wire logic line_code_select,         // bit 4
  input wire logic sample_number_format,     // bit 1
  input wire logic descrambler_on,           // descrambler active
  input wire logic link_subsys_reset,        // subsystem reset
  input wire logic mframe_counter_reset,     // counter reset
  input wire logic phy_enable,               // phy on
  input wire logic buffer_release,           // buffer released
  input wire logic datapath_enable           // datapath on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_PHY_FOLLOWS: assert property (phy_enable == !link_subsys_reset) else $error("phy enable wrong");
  AST_MFRAME_HELD: assert property (mframe_counter_reset == link_subsys_reset) else $error("counter reset wrong");
  AST_IDLE_QUIET: assert property (link_subsys_reset && $past(link_subsys_reset) |->
    lane_enable == '0 && !buffer_release && !descrambler_on) else $error("link off but active");
  AST_DESCR_64: assert property (phy_enable && $past(phy_enable) && $past(phy_enable, 2) && line_code_select
    |-> descrambler_on) else $error("64b66b not descrambled");
  AST_STREAM_HOLD: assert property (!link_subsys_reset || datapath_enable |=> $stable(stream_count))
    else $error("stream count changed");
  AST_MODE_HOLD: assert property (!link_subsys_reset |=> $stable(link_mode_select)) else $error("mode changed");
  AST_CTRL_HOLD: assert property (!link_subsys_reset |=>
    $stable({vendor_compat_mode, line_code_select, sample_number_format})) else $error("control changed");
  AST_REL_STICKY: assert property (buffer_release && phy_enable |=> buffer_release) else $error("release lost");
  AST_REL_CAUSE: assert property ($rose(buffer_release) |-> lane_enable != '0 &&
    ($past(lane_writing, 3) & lane_enable) == lane_enable) else $error("release before lanes");
  cover property ($rose(buffer_release));
  cover property (descrambler_on && line_code_select);
  cover property ($fell(phy_enable));
endmodule
bind serial_link_mode_config link_cfg_sva i_link_cfg_sva (.ref_clk, .resetn, .lane_writing, .link_mode_select,
  .stream_count, .lane_enable, .vendor_compat_mode, .line_code_select, .sample_number_format, .descrambler_on,
  .link_subsys_reset, .mframe_counter_reset, .phy_enable, .buffer_release, .datapath_enable);
`default_nettype wire

/* bench/far_link_tx.sv */
// behavioural far-end transmitter: lane start-up and release points
`timescale 1ns/1ps
`default_nettype none
module far_link_tx (
  input wire logic ref_clk,           // shared clock
  input wire logic phy_enable,        // receiver phy on
  input wire logic [1:0] lane_enable, // lanes listened to
  input wire logic slow,              // late lane start
  output logic [1:0] lane_writing,    // lanes delivering data
  output logic release_opportunity    // multiframe boundary pulse
);
  logic [4:0] age = 5'h00;
  logic [2:0] tick = 3'h0;
  initial lane_writing = 2'h0;
  initial release_opportunity = 1'b0;
  // age saturates so lanes never drop while the link stays up
  always @(posedge ref_clk)
  begin
    tick <= tick + 3'h1;
    age <= !phy_enable ? 5'h00 : (age == 5'h1F ? age : age + 5'h01);
    lane_writing <= (phy_enable && age > (slow ? 5'h10 : 5'h02)) ? lane_enable : 2'h0;
    release_opportunity <= phy_enable && tick == 3'h7;
  end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the link mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import link_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] bus_addr = '0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [3:0] mode_max_streams = 4'h2;
  logic [3:0] mode_base_lanes = 4'h1;
  logic slow = 1'b0;
  logic [LANES-1:0] lane_writing, lane_enable;
  logic [7:0] bus_rdata;
  logic [5:0] link_mode_select, release_delay;
  logic [3:0] stream_count;
  logic release_opportunity, vendor_compat_mode, line_code_select, sample_number_format, descrambler_on;
  logic link_subsys_reset, mframe_counter_reset, phy_enable, buffer_release, datapath_enable;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  serial_link_mode_config i_serial_link_mode_config (.ref_clk, .resetn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .mode_max_streams, .mode_base_lanes, .lane_writing, .release_opportunity, .bus_rdata, .link_mode_select,
    .stream_count, .lane_enable, .vendor_compat_mode, .line_code_select, .sample_number_format, .descrambler_on,
    .release_delay, .link_subsys_reset, .mframe_counter_reset, .phy_enable, .buffer_release, .datapath_enable);
  far_link_tx i_far_link_tx (.ref_clk, .phy_enable, .lane_enable, .slow, .lane_writing, .release_opportunity);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk("read data", e, bus_rdata);
  endtask
  task automatic up(input logic on);
    wr(LINK_ENABLE_OFS, {7'h00, on});
    repeat (3) @(posedge ref_clk);
    #1 chk("phy enable", {7'h00, on}, {7'h00, phy_enable});
  endtask
  task automatic wait_rel();
    for (int i = 0; i < 80 && buffer_release !== 1'b1; i++)
      @(posedge ref_clk);
    #1 chk("release", 8'h01, {7'h00, buffer_release});
  endtask
  task automatic t_reset();
    rd(LINK_MODE_OFS, LINK_MODE_RST);
    rd(STREAM_COUNT_OFS, 8'h01);
    rd(LINK_CONTROL_OFS, 8'h03);
    chk("format", 8'h01, {7'h00, sample_number_format});
    chk("subsys reset", 8'h01, {7'h00, link_subsys_reset});
    chk("frame reset", 8'h01, {7'h00, mframe_counter_reset});
    rd(RELEASE_DELAY_OFS, RELEASE_DELAY_RST);
    rd(LINK_ENABLE_OFS, 8'h00);
  endtask
  task automatic t_wide();
    wr(STREAM_COUNT_OFS, 8'hF4);
    rd(STREAM_COUNT_OFS, 8'h04);
    chk("streams out", 8'h04, {4'h0, stream_count});
    wr(LINK_MODE_OFS, 8'hFF);
    rd(LINK_MODE_OFS, 8'h3F);
    chk("mode out", 8'h3F, {2'h0, link_mode_select});
    wr(RELEASE_DELAY_OFS, 8'hFF);
    rd(RELEASE_DELAY_OFS, 8'h3F);
    chk("delay out", 8'h3F, {2'h0, release_delay});
    wr(LINK_CONTROL_OFS, 8'h7E);
    chk("vendor", 8'h01, {7'h00, vendor_compat_mode});
    chk("line code", 8'h01, {7'h00, line_code_select});
    up(1'b1);
    chk("lanes", 8'h03, {6'h00, lane_enable});
    chk("descrambler", 8'h01, {7'h00, descrambler_on});
    wait_rel();
    rd(MODE_INFO_OFS, 8'h02);
    rd(LINK_STATUS_OFS, 8'h03);
    rd(LINK_ENABLE_OFS, 8'h01);
    wr(RELEASE_DELAY_OFS, 8'h00);
    rd(RELEASE_DELAY_OFS, 8'h3F);
    wr(LINK_MODE_OFS, 8'h00);
    rd(LINK_MODE_OFS, 8'h3F);
    wr(STREAM_COUNT_OFS, 8'h02);
    rd(STREAM_COUNT_OFS, 8'h04);
    up(1'b0);
    chk("lanes off", 8'h00, {6'h00, lane_enable});
  endtask
  task automatic t_narrow();
    slow <= 1'b1;
    wr(DATAPATH_ENABLE_OFS, 8'h01);
    chk("datapath", 8'h01, {7'h00, datapath_enable});
    rd(DATAPATH_ENABLE_OFS, 8'h01);
    wr(STREAM_COUNT_OFS, 8'h02);
    rd(STREAM_COUNT_OFS, 8'h04);
    wr(DATAPATH_ENABLE_OFS, 8'h00);
    wr(STREAM_COUNT_OFS, 8'h02);
    rd(STREAM_COUNT_OFS, 8'h02);
    wr(LINK_CONTROL_OFS, 8'h01);
    chk("format", 8'h00, {7'h00, sample_number_format});
    chk("line code", 8'h00, {7'h00, line_code_select});
    chk("vendor", 8'h00, {7'h00, vendor_compat_mode});
    up(1'b1);
    chk("lanes", 8'h01, {6'h00, lane_enable});
    rd(MODE_INFO_OFS, 8'h01);
    chk("descrambler", 8'h01, {7'h00, descrambler_on});
    chk("early release", 8'h00, {7'h00, buffer_release});
    wait_rel();
    up(1'b0);
    wr(LINK_CONTROL_OFS, 8'h00);
    up(1'b1);
    chk("descrambler off", 8'h00, {7'h00, descrambler_on});
    rd(12'h0FF, 8'h00);
    up(1'b0);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_wide();
    t_narrow();
    close_out();
  end
endmodule
`default_nettype wire
